// ### hw/dsp_core.sv
// Setpoint, trigger, protection and digital port control
//
// Contract
// [R1] Main immediate current resets to ten percent
// [R2] Main pending current loads on armed trigger
// [R3] Auxiliary current immediate and pending, same behaviour
// [R4] Enabled overcurrent trip on constant current
// [R5] One overcurrent enable for all, resets off
// [R6] Only protection clear releases overcurrent latch
// [R7] Overvoltage trips output; level resets maximum
// [R8] Overvoltage immediate; overcurrent waits delay
// [R9] Overvoltage enable, resets disabled
// [R10] Protection clear releases overvoltage once gone
// [R11] Main immediate voltage resets to zero
// [R12] Main pending voltage loads on armed trigger
// [R13] Auxiliary voltage immediate and pending, zero
// [R14] Port bits zero, one drive lines
// [R15] Bit two: line three low or input
// [R16] Read returns bits zero, one, line three
// [R17] Port writes only in general function
// [R18] Port function selection kept non-volatile
// [R19] Clear needs faults gone, restores output state
// [R20] Delay postpones constant current recognition
// [R21] Armed trigger loads all levels, disarms
// [R22] Latches clear on reset; disable per channel
`timescale 1ns/1ps
`default_nettype none
`include "dsp_regs.svh"
module dsp_core #(
   parameter int LVL_W = `DSP_LVL_W,
   parameter int DEL_W = `DSP_DEL_W,
   parameter logic [DEL_W-1:0] DELAY_RST = DEL_W'(`DSP_DEL_CYC)
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic cmd_valid,
   input wire dsp_pkg::dsp_cmd_t cmd_code,
   input wire logic [LVL_W-1:0] cmd_data,
   input wire logic [DEL_W-1:0] cmd_delay,
   input wire logic initiate,
   input wire logic trigger,
   input wire logic out1_on_req,
   input wire logic out2_on_req,
   input wire logic [LVL_W-1:0] out1_volt_meas,
   input wire logic constant_current_state,
   input wire logic constant_current_state2,
   input wire logic nv_func_general,
   input wire logic port_line3_in,
   output logic [LVL_W-1:0] curr_level,
   output logic [LVL_W-1:0] curr2_level,
   output logic [LVL_W-1:0] volt_level,
   output logic [LVL_W-1:0] volt2_level,
   output logic [LVL_W-1:0] ov_level,
   output logic out1_enable,
   output logic out2_enable,
   output logic out1_disable,
   output logic out2_disable,
   output logic [`DSP_Q_W-1:0] ques_cond,
   output logic armed,
   output logic overcurrent_trip_ena,
   output logic overvoltage_trip_ena,
   output logic general_port_function,
   output logic port_line1_out,
   output logic port_line2_out,
   output logic port_line3_out,
   output logic port_line3_oe,
   output logic [2:0] port_data_rd,
   output logic nv_func_write
);
   logic [LVL_W-1:0] curr_r, curr_trig_r, curr2_r, curr2_trig_r;
   logic [LVL_W-1:0] volt_r, volt_trig_r, volt2_r, volt2_trig_r, ov_r;
   logic oc_ena_r, ov_ena_r, func_r, nv_wr_r, nv_load_r;
   logic [2:0] dig_r, dig_rd_r;
   logic oc1_lat_r, oc2_lat_r, ov_lat_r;
   logic [DEL_W-1:0] delay_r;
   logic dis1_r, dis2_r, en1_r, en2_r;
   dsp_pkg::dsp_arm_t arm_r;
   logic fire, restart, del_ok, ov_now, oc1_now, oc2_now, clr_ok;

   function automatic logic is_cmd(input dsp_pkg::dsp_cmd_t c);
      is_cmd = cmd_valid && (cmd_code == c);
   endfunction : is_cmd

   assign fire = trigger && (arm_r == dsp_pkg::DSP_ARM_WAIT); // [R21]
   // Any output current or voltage change restarts the delay so reprogramming does not trip overcurrent
   assign restart = fire || is_cmd(dsp_pkg::DSP_CMD_CURR)
      || is_cmd(dsp_pkg::DSP_CMD_CURR2) || is_cmd(dsp_pkg::DSP_CMD_VOLT)
      || is_cmd(dsp_pkg::DSP_CMD_VOLT2);
   assign ov_now = ov_ena_r && (out1_volt_meas > ov_r); // [R7]
   assign oc1_now = oc_ena_r && constant_current_state && del_ok; // [R4]
   assign oc2_now = oc_ena_r && constant_current_state2 && del_ok; // [R8]
   assign clr_ok = is_cmd(dsp_pkg::DSP_CMD_PROT_CLEAR) && !ov_now
      && !constant_current_state && !constant_current_state2; // [R19]

   dsp_delay #(
      .DEL_W(DEL_W)
   ) u_delay (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .restart(restart),
      .delay_cyc(delay_r),
      .expired(del_ok)
   );

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         arm_r <= dsp_pkg::DSP_ARM_IDLE;
      else if (fire)
         arm_r <= dsp_pkg::DSP_ARM_IDLE; // [R21]
      else if (initiate)
         arm_r <= dsp_pkg::DSP_ARM_WAIT;
   end

   // Main output levels
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         curr_r <= `DSP_CURR_RST; // [R1]
         curr_trig_r <= `DSP_CURR_RST;
         volt_r <= `DSP_VOLT_RST; // [R11]
         volt_trig_r <= `DSP_VOLT_RST; // [R12]
      end
      else
      begin
         if (fire)
         begin
            curr_r <= curr_trig_r; // [R2]
            volt_r <= volt_trig_r; // [R12]
         end
         else
         begin
            if (is_cmd(dsp_pkg::DSP_CMD_CURR))
               curr_r <= cmd_data; // [R1]
            if (is_cmd(dsp_pkg::DSP_CMD_VOLT))
               volt_r <= cmd_data; // [R11]
         end
         if (is_cmd(dsp_pkg::DSP_CMD_CURR_TRIG))
            curr_trig_r <= cmd_data;
         if (is_cmd(dsp_pkg::DSP_CMD_VOLT_TRIG))
            volt_trig_r <= cmd_data;
      end
   end

   // Auxiliary output levels
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         curr2_r <= `DSP_CURR_RST; // [R3]
         curr2_trig_r <= `DSP_CURR_RST;
         volt2_r <= `DSP_VOLT_RST; // [R13]
         volt2_trig_r <= `DSP_VOLT_RST;
      end
      else
      begin
         if (fire)
         begin
            curr2_r <= curr2_trig_r; // [R3]
            volt2_r <= volt2_trig_r; // [R13]
         end
         else
         begin
            if (is_cmd(dsp_pkg::DSP_CMD_CURR2))
               curr2_r <= cmd_data;
            if (is_cmd(dsp_pkg::DSP_CMD_VOLT2))
               volt2_r <= cmd_data;
         end
         if (is_cmd(dsp_pkg::DSP_CMD_CURR2_TRIG))
            curr2_trig_r <= cmd_data;
         if (is_cmd(dsp_pkg::DSP_CMD_VOLT2_TRIG))
            volt2_trig_r <= cmd_data;
      end
   end

   // Protection settings
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ov_r <= `DSP_LVL_MAX; // [R7]
         oc_ena_r <= 1'b0; // [R5]
         ov_ena_r <= 1'b0; // [R9]
         delay_r <= DELAY_RST; // [R20]
      end
      else
      begin
         if (is_cmd(dsp_pkg::DSP_CMD_OV_LEVEL))
            ov_r <= cmd_data;
         if (is_cmd(dsp_pkg::DSP_CMD_OC_ENA))
            oc_ena_r <= cmd_data[0]; // [R5]
         if (is_cmd(dsp_pkg::DSP_CMD_OV_ENA))
            ov_ena_r <= cmd_data[0]; // [R9]
         if (is_cmd(dsp_pkg::DSP_CMD_PROT_DELAY))
            delay_r <= cmd_delay;
      end
   end

   // Latches: a trip in the clear cycle wins over the clear
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         oc1_lat_r <= 1'b0; // [R22]
         oc2_lat_r <= 1'b0;
         ov_lat_r <= 1'b0;
      end
      else
      begin
         oc1_lat_r <= oc1_now || (oc1_lat_r && !clr_ok); // [R6]
         oc2_lat_r <= oc2_now || (oc2_lat_r && !clr_ok); // [R4]
         ov_lat_r <= ov_now || (ov_lat_r && !clr_ok); // [R10]
      end
   end

   // Outputs follow the requested state once latches release
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         dis1_r <= 1'b0;
         dis2_r <= 1'b0;
         en1_r <= 1'b0;
         en2_r <= 1'b0;
      end
      else
      begin
         dis1_r <= oc1_lat_r || ov_lat_r; // [R22]
         dis2_r <= oc2_lat_r;
         en1_r <= out1_on_req && !(oc1_lat_r || ov_lat_r); // [R19]
         en2_r <= out2_on_req && !oc2_lat_r;
      end
   end

   // Digital port; function is mirrored to external storage and reloaded from it after reset
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         dig_r <= `DSP_DIG_RST; // [R17]
         func_r <= 1'b0;
         nv_load_r <= 1'b1;
         nv_wr_r <= 1'b0;
         dig_rd_r <= `DSP_DIG_RST;
      end
      else
      begin
         nv_load_r <= 1'b0;
         nv_wr_r <= is_cmd(dsp_pkg::DSP_CMD_DIG_FUNC); // [R18]
         // Stored choice returns a cycle after reset; a write wins
         if (is_cmd(dsp_pkg::DSP_CMD_DIG_FUNC))
            func_r <= cmd_data[0];
         else if (nv_load_r)
            func_r <= nv_func_general; // [R18]
         if (is_cmd(dsp_pkg::DSP_CMD_DIG_DATA) && func_r)
            dig_r <= cmd_data[2:0]; // [R17]
         dig_rd_r <= {port_line3_in, dig_r[1:0]}; // [R16]
      end
   end

   assign curr_level = curr_r;
   assign curr2_level = curr2_r;
   assign volt_level = volt_r;
   assign volt2_level = volt2_r;
   assign ov_level = ov_r;
   assign out1_enable = en1_r;
   assign out2_enable = en2_r;
   assign out1_disable = dis1_r;
   assign out2_disable = dis2_r;
   assign armed = (arm_r == dsp_pkg::DSP_ARM_WAIT);
   assign overcurrent_trip_ena = oc_ena_r;
   assign overvoltage_trip_ena = ov_ena_r;
   assign general_port_function = func_r;
   assign port_line1_out = dig_r[0]; // [R14]
   assign port_line2_out = dig_r[1]; // [R14]
   assign port_line3_out = 1'b0; // [R15]
   assign port_line3_oe = ~dig_r[`DSP_DIG_LINE3]; // [R15]
   assign port_data_rd = dig_rd_r;
   assign nv_func_write = nv_wr_r;
   always_comb
   begin
      ques_cond = '0;
      ques_cond[`DSP_Q_OV] = ov_lat_r; // [R7]
      ques_cond[`DSP_Q_OC] = oc1_lat_r; // [R4]
      ques_cond[`DSP_Q_OC2] = oc2_lat_r;
   end

   sequence s_arm_trig;
      armed && trigger;
   endsequence
   AST_TRIG_LOAD: assert property ( // [R21]
      @(posedge core_clk) disable iff (sys_rst)
      s_arm_trig |=> (curr_r == $past(curr_trig_r)) && !armed)
      else $error("armed trigger did not load levels");
   AST_VOLT_LOAD: assert property ( // [R12]
      @(posedge core_clk) disable iff (sys_rst)
      s_arm_trig |=> volt_r == $past(volt_trig_r))
      else $error("voltage not loaded on trigger");
   AST_AUX_LOAD: assert property ( // [R3]
      @(posedge core_clk) disable iff (sys_rst)
      s_arm_trig |=> curr2_r == $past(curr2_trig_r))
      else $error("aux current not loaded on trigger");
   AST_NO_TRIG: assert property ( // [R2]
      @(posedge core_clk) disable iff (sys_rst)
      trigger && !armed && !is_cmd(dsp_pkg::DSP_CMD_CURR)
      |=> $stable(curr_r))
      else $error("unarmed trigger changed current");
   AST_OV_TRIP: assert property ( // [R8]
      @(posedge core_clk) disable iff (sys_rst)
      ov_ena_r && out1_volt_meas > ov_r |=> ov_lat_r ##1 out1_disable)
      else $error("overvoltage did not trip at once");
   AST_OC_OFF: assert property ( // [R5]
      @(posedge core_clk) disable iff (sys_rst)
      !oc_ena_r && !oc1_lat_r |=> !oc1_lat_r)
      else $error("overcurrent tripped while disabled");
   AST_LATCH_HOLD: assert property ( // [R6]
      @(posedge core_clk) disable iff (sys_rst)
      oc1_lat_r && !is_cmd(dsp_pkg::DSP_CMD_PROT_CLEAR) |=> oc1_lat_r)
      else $error("overcurrent latch dropped without clear");
   AST_DIG_GATE: assert property ( // [R17]
      @(posedge core_clk) disable iff (sys_rst)
      !func_r |=> dig_r == $past(dig_r))
      else $error("port data changed outside general function");
   AST_OUT_OFF: assert property ( // [R19]
      @(posedge core_clk) disable iff (sys_rst)
      ov_lat_r |=> !out1_enable)
      else $error("output on while latched");
   sequence s_oc1_hit;
      oc_ena_r && constant_current_state && del_ok;
   endsequence
   AST_OC_TRIP: assert property ( // [R4]
      @(posedge core_clk) disable iff (sys_rst)
      s_oc1_hit |=> ques_cond[`DSP_Q_OC] ##1 out1_disable)
      else $error("overcurrent did not latch output off");
   AST_OC2_TRIP: assert property ( // [R4]
      @(posedge core_clk) disable iff (sys_rst)
      oc_ena_r && constant_current_state2 && del_ok
      |=> ques_cond[`DSP_Q_OC2] ##1 out2_disable)
      else $error("aux overcurrent did not latch output off");
   // Counter must hold off recognition right after a level change
   AST_DELAY_HOLD: assert property ( // [R20]
      @(posedge core_clk) disable iff (sys_rst)
      restart && delay_r != '0 |=> !del_ok)
      else $error("constant current seen inside protection delay");
   AST_CLEAR: assert property ( // [R10]
      @(posedge core_clk) disable iff (sys_rst)
      is_cmd(dsp_pkg::DSP_CMD_PROT_CLEAR) && !ov_now
      && !constant_current_state && !constant_current_state2
      |=> ques_cond == '0)
      else $error("clear with no fault left a latch set");
   AST_NV_LOAD: assert property ( // [R18]
      @(posedge core_clk) disable iff (sys_rst)
      nv_load_r && !cmd_valid
      |=> general_port_function == $past(nv_func_general))
      else $error("stored port function not restored");
   AST_PORT_RD: assert property ( // [R16]
      @(posedge core_clk) disable iff (sys_rst)
      general_port_function
      |=> port_data_rd[1:0] == $past(dig_r[1:0]))
      else $error("port read does not return written bits");
endmodule : dsp_core
`default_nettype wire

// ### hw/dsp_regs.svh
// Constants for the dc source setpoint and protection block
`ifndef DSP_REGS_SVH
`define DSP_REGS_SVH
`define DSP_LVL_W 16
`define DSP_LVL_MAX 16'hffff
`define DSP_CURR_RST 16'h1999
`define DSP_VOLT_RST 16'h0000
`define DSP_DIG_RST 3'h0
`define DSP_CLK_HZ 40000000
`define DSP_DEL_US 80000
`define DSP_DEL_CYC ((`DSP_DEL_US * (`DSP_CLK_HZ / 1000000)))
`define DSP_DEL_W 32
`define DSP_CMD_W 4
`define DSP_DIG_LINE3 2
`define DSP_Q_OV 0
`define DSP_Q_OC 1
`define DSP_Q_OC2 12
`define DSP_Q_W 16
`endif

// ### hw/dsp_pkg.sv
// Types shared by the dc source setpoint and protection block
package dsp_pkg;
   typedef enum logic [3:0]
   {
      DSP_CMD_NONE = 4'h0,
      DSP_CMD_CURR = 4'h1,
      DSP_CMD_CURR_TRIG = 4'h2,
      DSP_CMD_CURR2 = 4'h3,
      DSP_CMD_CURR2_TRIG = 4'h4,
      DSP_CMD_VOLT = 4'h5,
      DSP_CMD_VOLT_TRIG = 4'h6,
      DSP_CMD_VOLT2 = 4'h7,
      DSP_CMD_VOLT2_TRIG = 4'h8,
      DSP_CMD_OV_LEVEL = 4'h9,
      DSP_CMD_OC_ENA = 4'ha,
      DSP_CMD_OV_ENA = 4'hb,
      DSP_CMD_DIG_DATA = 4'hc,
      DSP_CMD_DIG_FUNC = 4'hd,
      DSP_CMD_PROT_CLEAR = 4'he,
      DSP_CMD_PROT_DELAY = 4'hf
   } dsp_cmd_t;
   typedef enum logic [1:0]
   {
      DSP_ARM_IDLE = 2'b00,
      DSP_ARM_WAIT = 2'b01
   } dsp_arm_t;
endpackage : dsp_pkg

// ### hw/dsp_delay.sv
// Protection delay counter gating constant current recognition
`timescale 1ns/1ps
`default_nettype none
`include "dsp_regs.svh"
module dsp_delay #(
   parameter int DEL_W = `DSP_DEL_W
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic restart,
   input wire logic [DEL_W-1:0] delay_cyc,
   output logic expired
);
   logic [DEL_W-1:0] cnt_r;
   // Restart on each programmed output change
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         cnt_r <= '0;
      else if (restart)
         cnt_r <= delay_cyc;
      else if (cnt_r != '0)
         cnt_r <= cnt_r - 1'b1;
   end
   assign expired = (cnt_r == '0) && !restart; // [R20]
endmodule : dsp_delay
`default_nettype wire

// ### test/dsp_load.sv
// Output stage stand-in: current limit and voltage sensing
`timescale 1ns/1ps
`default_nettype none
module dsp_load (
   input wire logic core_clk,
   input wire logic [15:0] curr_level,
   input wire logic [15:0] curr2_level,
   input wire logic [15:0] volt_level,
   input wire logic [15:0] load1,
   input wire logic [15:0] load2,
   input wire logic [15:0] bump,
   output logic cc1,
   output logic cc2,
   output logic [15:0] volt_meas
);
   // Registered sense path; cause stays while load exceeds the limit
   always_ff @(posedge core_clk)
   begin
      cc1 <= load1 > curr_level;
      cc2 <= load2 > curr2_level;
      volt_meas <= volt_level + bump;
   end
endmodule : dsp_load
`default_nettype wire

// ### test/dc_source_setpoint_protection_test.sv
// Self-checking bench for the setpoint and protection core
`timescale 1ns/1ps
`default_nettype none
module dc_source_setpoint_protection_test;
   logic core_clk, sys_rst, cmd_valid, initiate, trigger, ext_l3;
   logic out1_on_req, out2_on_req, nv_func_general, port_line3_in;
   logic constant_current_state, constant_current_state2;
   dsp_pkg::dsp_cmd_t cmd_code;
   logic [15:0] cmd_data, out1_volt_meas, curr_level, curr2_level;
   logic [15:0] volt_level, volt2_level, ov_level, ques_cond;
   logic [15:0] load1, load2, bump;
   logic [31:0] cmd_delay;
   logic out1_enable, out2_enable, out1_disable, out2_disable, armed;
   logic overcurrent_trip_ena, overvoltage_trip_ena, general_port_function;
   logic port_line1_out, port_line2_out, port_line3_out, port_line3_oe;
   logic [2:0] port_data_rd;
   logic nv_func_write;
   logic [15:0] act [5];
   logic [15:0] pend [4];
   int err_count, samples_checked, seed, i, n;
   // Pin three wire level: device drives low, else the outside level
   assign port_line3_in = port_line3_oe ? port_line3_out : ext_l3;
   dsp_core #(.DELAY_RST(32'h0000000a)) u_dut (.core_clk, .sys_rst,
      .cmd_valid, .cmd_code, .cmd_data, .cmd_delay, .initiate, .trigger,
      .out1_on_req, .out2_on_req, .out1_volt_meas, .constant_current_state,
      .constant_current_state2, .nv_func_general, .port_line3_in,
      .curr_level, .curr2_level, .volt_level, .volt2_level, .ov_level,
      .out1_enable, .out2_enable, .out1_disable, .out2_disable, .ques_cond,
      .armed, .overcurrent_trip_ena, .overvoltage_trip_ena,
      .general_port_function, .port_line1_out, .port_line2_out,
      .port_line3_out, .port_line3_oe, .port_data_rd, .nv_func_write);
   dsp_load u_load (.core_clk, .curr_level, .curr2_level, .volt_level,
      .load1, .load2, .bump, .cc1(constant_current_state),
      .cc2(constant_current_state2), .volt_meas(out1_volt_meas));
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic pause(input int n);
      repeat (n) @(negedge core_clk);
   endtask : pause
   // Model follows every accepted level command, codes 1 to 9
   task automatic cmd(input dsp_pkg::dsp_cmd_t c, input logic [15:0] d);
      int k;
      @(negedge core_clk);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_data = d;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      k = int'(c);
      if (k >= 1 && k <= 9 && k % 2 == 1) act[k / 2] = d;
      if (k >= 2 && k <= 8 && k % 2 == 0) pend[k / 2 - 1] = d;
   endtask : cmd
   task automatic cmp_lvls();
      chk(curr_level, act[0]);
      chk(curr2_level, act[1]);
      chk(volt_level, act[2]);
      chk(volt2_level, act[3]);
      chk(ov_level, act[4]);
   endtask : cmp_lvls
   initial
   begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      conclude();
   end
   initial
   begin
      seed = 52351;
      err_count = 0;
      samples_checked = 0;
      {cmd_valid, initiate, trigger, out1_on_req, out2_on_req} = 5'h00;
      nv_func_general = 1'b0;
      cmd_code = dsp_pkg::DSP_CMD_NONE;
      cmd_data = 16'h0000;
      cmd_delay = 32'h0000000c;
      {load1, load2, bump} = {16'h0000, 16'h0000, 16'h0000};
      ext_l3 = 1'b1;
      act = '{16'h1999, 16'h1999, 16'h0000, 16'h0000, 16'hffff};
      pend = '{16'h1999, 16'h1999, 16'h0000, 16'h0000};
      sys_rst = 1'b1;
      repeat (16) @(negedge core_clk);
      sys_rst = 1'b0;
      pause(1);
      cmp_lvls();
      chk(ques_cond, 16'h0000);
      chk(overcurrent_trip_ena, 16'h0000);
      chk(overvoltage_trip_ena, 16'h0000);
      // Line three is driven low after reset, so it reads back low
      chk({general_port_function, port_data_rd}, 16'h0000);
      for (i = 0; i < 10; i++)
      begin
         cmd(dsp_pkg::dsp_cmd_t'(4'(2 * (i % 5) + 1)), 16'($random(seed)));
         cmp_lvls();
      end
      for (i = 0; i < 4; i++)
         cmd(dsp_pkg::dsp_cmd_t'(4'(2 * i + 2)), 16'($random(seed)));
      trigger = 1'b1;
      pause(1);
      trigger = 1'b0;
      pause(1);
      cmp_lvls();
      initiate = 1'b1;
      pause(1);
      initiate = 1'b0;
      chk(armed, 16'h0001);
      trigger = 1'b1;
      pause(1);
      trigger = 1'b0;
      for (i = 0; i < 4; i++)
         act[i] = pend[i];
      cmp_lvls();
      chk(armed, 16'h0000);
      cmd(dsp_pkg::DSP_CMD_DIG_DATA, 16'h0003);
      pause(1);
      chk({port_line2_out, port_line1_out}, 16'h0000);
      cmd(dsp_pkg::DSP_CMD_DIG_FUNC, 16'h0001);
      n = 0;
      for (i = 0; i < 3; i++)
      begin
         n += int'(nv_func_write);
         pause(1);
      end
      chk(16'(n), 16'h0001);
      chk(general_port_function, 16'h0001);
      for (i = 0; i < 8; i++)
      begin
         ext_l3 = 1'($random(seed));
         cmd(dsp_pkg::DSP_CMD_DIG_DATA, 16'(i));
         pause(1);
         chk({port_line2_out, port_line1_out}, 16'(i % 4));
         chk({port_line3_oe, port_line3_out}, 16'(i < 4 ? 2 : 0));
         chk(port_data_rd, 16'(i % 4 + (i >= 4 && ext_l3 ? 4 : 0)));
      end
      // Trip disabled: a standing overload must not shut down
      {out1_on_req, out2_on_req} = 2'b11;
      cmd(dsp_pkg::DSP_CMD_PROT_DELAY, 16'h0000);
      cmd(dsp_pkg::DSP_CMD_CURR, 16'h1000);
      load1 = 16'hffff;
      pause(30);
      chk({out1_disable, out1_enable}, 16'h0001);
      load1 = 16'h0000;
      cmd(dsp_pkg::DSP_CMD_OC_ENA, 16'h0001);
      cmd(dsp_pkg::DSP_CMD_CURR, 16'h0800);
      load1 = 16'h9000;
      pause(4);
      chk(out1_disable, 16'h0000);
      for (i = 0; i < 40 && out1_disable !== 1'b1; i++)
         @(negedge core_clk);
      // Countdown, then one edge to latch and one to disable
      chk(16'(i + 4), 16'(cmd_delay + 2));
      chk({out1_disable, out1_enable, ques_cond[1]}, 16'h0005);
      cmd(dsp_pkg::DSP_CMD_PROT_CLEAR, 16'h0000);
      pause(3);
      chk(out1_disable, 16'h0001);
      load1 = 16'h0000;
      pause(3);
      cmd(dsp_pkg::DSP_CMD_PROT_CLEAR, 16'h0000);
      pause(3);
      chk({out1_disable, out1_enable}, 16'h0001);
      // Known limit so the overload always exceeds it
      cmd(dsp_pkg::DSP_CMD_CURR2, 16'h0800);
      load2 = 16'hffff;
      for (i = 0; i < 40 && out2_disable !== 1'b1; i++)
         @(negedge core_clk);
      chk({out2_disable, ques_cond[12]}, 16'h0003);
      chk(out1_disable, 16'h0000);
      load2 = 16'h0000;
      pause(3);
      cmd(dsp_pkg::DSP_CMD_PROT_CLEAR, 16'h0000);
      pause(3);
      chk({out2_disable, out2_enable}, 16'h0001);
      cmd(dsp_pkg::DSP_CMD_VOLT, 16'h1000);
      cmd(dsp_pkg::DSP_CMD_OV_LEVEL, 16'h2000);
      bump = 16'h1800;
      pause(6);
      chk(out1_disable, 16'h0000);
      cmd(dsp_pkg::DSP_CMD_OV_ENA, 16'h0001);
      for (i = 0; i < 3 && out1_disable !== 1'b1; i++)
         @(negedge core_clk);
      // Trips while the delay from the voltage change still runs
      chk(16'(i), 16'h0002);
      chk({out1_disable, ques_cond[0]}, 16'h0003);
      cmd(dsp_pkg::DSP_CMD_PROT_CLEAR, 16'h0000);
      pause(3);
      chk(out1_disable, 16'h0001);
      bump = 16'h0000;
      pause(3);
      cmd(dsp_pkg::DSP_CMD_PROT_CLEAR, 16'h0000);
      pause(3);
      chk({out1_disable, out1_enable, ques_cond[0]}, 16'h0002);
      cmp_lvls();
      bump = 16'h1800;
      pause(3);
      chk(ques_cond[0], 16'h0001);
      // Second reset with a latch set: it drops, stored function returns
      nv_func_general = 1'b1;
      sys_rst = 1'b1;
      pause(2);
      sys_rst = 1'b0;
      act = '{16'h1999, 16'h1999, 16'h0000, 16'h0000, 16'hffff};
      pend = '{16'h1999, 16'h1999, 16'h0000, 16'h0000};
      chk(general_port_function, 16'h0000);
      pause(1);
      cmp_lvls();
      chk(general_port_function, 16'h0001);
      chk(ques_cond, 16'h0000);
      chk({out1_disable, out2_disable}, 16'h0000);
      chk(overvoltage_trip_ena, 16'h0000);
      initiate = 1'b1;
      pause(1);
      initiate = 1'b0;
      trigger = 1'b1;
      pause(1);
      trigger = 1'b0;
      for (i = 0; i < 4; i++)
         act[i] = pend[i];
      cmp_lvls();
      conclude();
   end
endmodule : dc_source_setpoint_protection_test
`default_nettype wire
